/* wrxcs_regs.sv */
/*
 * Control, event and status register bank of the wireless power receiver.
 * Assumes analog comparator levels arrive asynchronously and are
 * synchronised here; the bus master follows the plain strobe protocol.
 */
// Design decision made here: the plain strobed port.
// Operation
// - Writing A5 to the key field unlocks the control register.
// - Fault bit high drives the interrupt pin low, else released.
// - Clamp select 1 defers clamp turn-on to coil zero crossing.
// - Modulator select 0 defers turn-on to zero crossing, 1 direct.
// - Modulator, clamp and load dump enables switch their transistors.
// - Coil inputs silent over 8 ms set the downlink timeout flag.
// - Output toggle while toggle flag set sets the overrun flag.
// - Any output on/off change sets the output toggle flag.
// - Rectifier above threshold sets the rectifier overvoltage flag.
// - Output current above limit sets the overcurrent flag.
// - Output above 1.25 times level sets the overvoltage flag.
// - Die above 140 or 130 degrees sets the thermal flags.
// - Event flags stay set until software writes one to them.
// - Enable bits gate each event flag except overrun onto the interrupt request.
// - Status register shows live rectifier, output and current levels.
// - Thermal status levels follow comparator hysteresis, shown live.
`timescale 1ns/100ps
`default_nettype none
module wrxcs_regs #(
	parameter int TMO_COUNT = wrxcs_pkg::TMO_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Register port
	input wire logic [wrxcs_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Analog levels
	input wire logic i_coil_active,
	input wire logic i_coil_zero,
	input wire logic i_rectifier_overvolt_level,
	input wire logic i_output_on_level,
	input wire logic i_output_overcurrent_level,
	input wire logic i_output_overvolt_level,
	input wire logic i_thermal_shutdown_level,
	input wire logic i_thermal_warning_level,
	// Switch drives
	output logic o_modulator_switch_on,
	output logic o_clamp_switch_on,
	output logic o_load_dump_switch_on,
	// Open-drain host interrupt pin
	input wire logic i_host_irq_pin,
	output logic o_host_irq_pin,
	output logic o_host_irq_pin_oe,
	// Interrupt
	output logic o_irq
);
	import wrxcs_pkg::*;

	localparam int NSYNC = 9;

	// Two-flop synchronisers for all asynchronous inputs. They carry no
	// reset: reset is held long enough to flush them, and a reset here
	// would only delay the first true sample.
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [NSYNC-1:0] next_sync_a;
	logic [NSYNC-1:0] next_sync_b;
	logic coil_act_s;
	logic coil_zero_s;
	logic rect_s;
	logic out_s;
	logic ocl_s;
	logic ov_s;
	logic tsd_s;
	logic twn_s;
	logic pin_s;

	always_comb begin
		next_sync_a = {i_host_irq_pin, i_thermal_warning_level,
			i_thermal_shutdown_level, i_output_overvolt_level,
			i_output_overcurrent_level, i_output_on_level,
			i_rectifier_overvolt_level, i_coil_zero, i_coil_active};
		next_sync_b = sync_a;
	end

	always_ff @(posedge i_sys_clk) begin
		sync_a <= next_sync_a;
		sync_b <= next_sync_b;
	end

	assign coil_act_s = sync_b[0];
	assign coil_zero_s = sync_b[1];
	assign rect_s = sync_b[2];
	assign out_s = sync_b[3];
	assign ocl_s = sync_b[4];
	assign ov_s = sync_b[5];
	assign tsd_s = sync_b[6];
	assign twn_s = sync_b[7];
	assign pin_s = sync_b[8];

	// Register state, grouped by function.
	logic [7:0] key;
	logic [7:0] next_key;
	logic unlocked;
	logic next_unlocked;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] enables;
	logic [7:0] next_enables;
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic irq;
	logic next_irq;
	logic [7:0] live;
	logic [7:0] live_prev;
	logic [7:0] next_live_prev;
	logic [7:0] rise;
	logic [7:0] toggle;
	logic [23:0] silent_cnt;
	logic [23:0] next_silent_cnt;
	logic tmo_done;
	logic next_tmo_done;
	logic tmo_event;
	logic mod_on;
	logic next_mod_on;
	logic clamp_on;
	logic next_clamp_on;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic key_wr;
	logic ctrl_wr;
	logic int_wr;
	logic [7:0] events;
	logic [7:0] clear;

	// Decoded write strobes; the address must match exactly.
	assign key_wr = i_wr && (i_addr == OFS_KEY);
	assign ctrl_wr = i_wr && (i_addr == OFS_CTRL);
	assign int_wr = i_wr && (i_addr == OFS_INT);

	// Live levels in status register order, and their edges.
	assign live = {2'h0, rect_s, out_s, ocl_s, ov_s, tsd_s, twn_s};
	assign rise = live & ~live_prev;
	assign toggle = live ^ live_prev;

	// Key and lock. The unlock is single shot, so only the first control write
	// after the key can change the switches; any other key value
	// withdraws a pending unlock.
	always_comb begin
		next_key = key;
		next_unlocked = unlocked;
		if (key_wr) begin
			next_key = i_wdata[7:0];
			next_unlocked = (i_wdata[7:0] == UNLOCK_VALUE);
		end else if (ctrl_wr) begin
			next_unlocked = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			key <= 8'h00;
			unlocked <= 1'b0;
		end else begin
			key <= next_key;
			unlocked <= next_unlocked;
		end
	end

	// Control register. Locked writes are dropped without any error
	// indication, so software should read back after a change.
	always_comb begin
		next_ctrl = ctrl;
		if (ctrl_wr && unlocked) begin
			next_ctrl = i_wdata[7:0] & CTL_MASK;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ctrl <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Edge history. Reset clears it to the idle low level of every
	// comparator, so a level that is already high at reset release
	// reports one event.
	always_comb begin
		next_live_prev = live;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			live_prev <= 8'h00;
		end else begin
			live_prev <= next_live_prev;
		end
	end

	// Silence counter restarts on any coil activity and reports once per
	// silent spell. The width covers the default count at 40 MHz; a
	// larger count parameter would be cut to the low bits.
	always_comb begin
		next_silent_cnt = silent_cnt;
		next_tmo_done = tmo_done;
		tmo_event = 1'b0;
		if (coil_act_s) begin
			next_silent_cnt = 24'h00_0000;
			next_tmo_done = 1'b0;
		end else if (silent_cnt < TMO_COUNT[23:0]) begin
			next_silent_cnt = silent_cnt + 24'h00_0001;
		end else if (!tmo_done) begin
			next_tmo_done = 1'b1;
			tmo_event = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			silent_cnt <= 24'h00_0000;
			tmo_done <= 1'b0;
		end else begin
			silent_cnt <= next_silent_cnt;
			tmo_done <= next_tmo_done;
		end
	end

	// Interrupt enables; the reserved position never holds a one.
	always_comb begin
		next_enables = enables;
		if (int_wr) begin
			next_enables = i_wdata[7:0] & EN_MASK;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			enables <= 8'h00;
		end else begin
			enables <= next_enables;
		end
	end

	// Event flags and interrupt. Comparator events are rising edges;
	// the output toggle event fires on either edge of the output level.
	always_comb begin
		events = 8'h00;
		clear = 8'h00;
		events[EV_TMO] = tmo_event;
		events[EV_RECT] = rise[ST_RECT];
		events[EV_TOG] = toggle[ST_OUT];
		events[EV_OVR] = toggle[ST_OUT] & flags[EV_TOG];
		events[EV_OCL] = rise[ST_OCL];
		events[EV_OV] = rise[ST_OV];
		events[EV_TSD] = rise[ST_TSD];
		events[EV_TWN] = rise[ST_TWN];
		if (int_wr) begin
			clear = i_wdata[FLAG_LSB+7:FLAG_LSB];
		end
		// A new event in the clearing cycle survives the clear.
		next_flags = (flags & ~clear) | events;
		// The interrupt follows the values the registers are about to
		// hold, so it rises with the flag and falls with the clear.
		next_irq = |(next_flags & next_enables);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			flags <= 8'h00;
			irq <= 1'b0;
		end else begin
			flags <= next_flags;
			irq <= next_irq;
		end
	end

	// Switch drives. A requested turn-on may wait for 0 V on the coil;
	// turn-off is always immediate, so a cleared enable can never leave
	// a switch stuck on while the coil waits for a zero crossing.
	always_comb begin
		next_mod_on = mod_on;
		next_clamp_on = clamp_on;
		if (!ctrl[CTL_MOD]) begin
			next_mod_on = 1'b0;
		end else if (ctrl[CTL_MOD_SEL] || coil_zero_s) begin
			next_mod_on = 1'b1;
		end
		if (!ctrl[CTL_CLAMP]) begin
			next_clamp_on = 1'b0;
		end else if (!ctrl[CTL_CLAMP_SEL] || coil_zero_s) begin
			next_clamp_on = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mod_on <= 1'b0;
			clamp_on <= 1'b0;
		end else begin
			mod_on <= next_mod_on;
			clamp_on <= next_clamp_on;
		end
	end

	// Read data stands for one cycle after the read strobe and is zero
	// otherwise, so a bus that ORs several slaves needs no extra gating.
	// The pin word shows whether anything holds the host pin low.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				OFS_KEY: next_rdata = {24'h00_0000, key};
				OFS_CTRL: next_rdata = {24'h00_0000, ctrl};
				OFS_INT: next_rdata = {8'h00, flags, 8'h00, enables};
				OFS_STS: next_rdata = {24'h00_0000, live};
				OFS_IRQ: next_rdata = {31'h0000_0000, pin_s};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Outputs straight from registers.
	assign o_rdata = rdata;
	assign o_irq = irq;
	assign o_modulator_switch_on = mod_on;
	assign o_clamp_switch_on = clamp_on;
	assign o_load_dump_switch_on = ctrl[CTL_DUMP];
	// Open drain: only ever drives low, released otherwise, so the pin
	// idles at its pull-up while the fault bit is clear.
	assign o_host_irq_pin = 1'b0;
	assign o_host_irq_pin_oe = ctrl[CTL_FAULT];
endmodule // wrxcs_regs
`default_nettype wire

/* wrxcs_pkg.sv */
/*
 * Package for the wireless receiver control and status register bank:
 * register offsets, field positions, key value and timing constants.
 * Assumes a 40 MHz system clock and word-aligned byte addresses.
 */
`default_nettype none
package wrxcs_pkg;
	localparam int ADDR_W = 32;
	localparam logic [31:0] BASE_ADDR = 32'h4016_0000;
	localparam logic [31:0] OFS_KEY = 32'h4016_0000;
	localparam logic [31:0] OFS_CTRL = 32'h4016_0004;
	localparam logic [31:0] OFS_INT = 32'h4016_0008;
	localparam logic [31:0] OFS_STS = 32'h4016_000C;
	localparam logic [31:0] OFS_IRQ = 32'h4016_0010;
	localparam logic [7:0] UNLOCK_VALUE = 8'hA5;
	// Control register field positions.
	localparam int CTL_FAULT = 7;
	localparam int CTL_CLAMP_SEL = 4;
	localparam int CTL_MOD_SEL = 3;
	localparam int CTL_MOD = 2;
	localparam int CTL_CLAMP = 1;
	localparam int CTL_DUMP = 0;
	localparam logic [7:0] CTL_MASK = 8'h9F;
	// Event positions in the flag byte (bits 23:16) and enable byte (7:0).
	localparam int EV_TMO = 7;
	localparam int EV_OVR = 6;
	localparam int EV_RECT = 5;
	localparam int EV_TOG = 4;
	localparam int EV_OCL = 3;
	localparam int EV_OV = 2;
	localparam int EV_TSD = 1;
	localparam int EV_TWN = 0;
	localparam int FLAG_LSB = 16;
	localparam logic [7:0] EN_MASK = 8'hBF;
	// Live status positions.
	localparam int ST_RECT = 5;
	localparam int ST_OUT = 4;
	localparam int ST_OCL = 3;
	localparam int ST_OV = 2;
	localparam int ST_TSD = 1;
	localparam int ST_TWN = 0;
	// Downlink silence timeout.
	localparam int CLK_HZ = 40_000_000;
	localparam int TMO_MS = 8;
	localparam int TMO_CYCLES = TMO_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

/* wrxcs_analog.sv */
/* Analog stage model: comparator levels, coil activity and zero crossing.
 * Assumes the bench sets the conditions; the host pin has a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module wrxcs_analog (
	// Conditions set by the bench
	input wire logic [5:0] i_cond,
	input wire logic i_coil_run,
	input wire logic i_zero,
	// Host pin drive from the bank
	input wire logic i_pin_oe,
	input wire logic i_pin_val,
	// Levels toward the bank
	output logic [5:0] o_lv,
	output logic o_coil_active,
	output logic o_coil_zero,
	output logic o_pin
);
	// Thermal levels arrive already hysteretic from the comparators.
	assign o_lv = i_cond;
	assign o_coil_active = i_coil_run;
	assign o_coil_zero = i_zero;
	// A released pin is pulled up, never left floating.
	assign o_pin = i_pin_oe ? i_pin_val : 1'b1;
endmodule // wrxcs_analog
`default_nettype wire

/* wrxcs_regs_assertions.sv */
/* Port checker for the receiver register bank.
 * Assumes it is bound to every bank instance below. */
`timescale 1ns/100ps
`default_nettype none
module wrxcs_chk (
	// Clock, reset and bus
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [wrxcs_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	// Watched outputs
	input wire logic o_modulator_switch_on,
	input wire logic o_clamp_switch_on,
	input wire logic o_load_dump_switch_on,
	input wire logic o_host_irq_pin,
	input wire logic o_host_irq_pin_oe,
	input wire logic o_irq
);
	import wrxcs_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic unlk, next_unlk, acc;
	logic [7:0] lastw, next_lastw;
	logic int_wr;
	assign acc = i_wr && i_addr == OFS_CTRL && unlk;
	assign int_wr = i_wr && i_addr == OFS_INT;
	always_comb begin
		next_unlk = unlk;
		next_lastw = acc ? i_wdata[7:0] : lastw;
		if (i_wr && i_addr == OFS_KEY)
			next_unlk = i_wdata[7:0] == UNLOCK_VALUE;
		else if (i_wr && i_addr == OFS_CTRL)
			next_unlk = 1'b0;
	end
	always_ff @(posedge i_sys_clk) begin
		unlk <= i_sys_rst ? 1'b0 : next_unlk;
		lastw <= i_sys_rst ? 8'h00 : next_lastw;
	end
	AST_LOCKED: assert property (i_wr && i_addr == OFS_CTRL && !unlk
		|=> $stable({o_host_irq_pin_oe, o_load_dump_switch_on})[*2])
		else $error("locked control write changed outputs");
	AST_DUMP: assert property (acc
		|-> ##2 o_load_dump_switch_on == lastw[0])
		else $error("load dump switch does not follow its enable");
	AST_FAULT: assert property (acc
		|-> ##2 o_host_irq_pin_oe == lastw[7] && !o_host_irq_pin)
		else $error("host pin drive does not follow fault bit");
	AST_CLAMP_DIRECT: assert property (acc && !i_wdata[4]
		|-> ##2 o_clamp_switch_on == lastw[1])
		else $error("direct clamp does not follow its enable");
	AST_MOD_DIRECT: assert property (acc && i_wdata[3]
		|-> ##2 o_modulator_switch_on == lastw[2])
		else $error("direct modulator does not follow its enable");
	AST_IRQ_HOLD: assert property ($fell(o_irq)
		|-> $past(int_wr))
		else $error("interrupt fell without an event register write");
	AST_READ_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_STS_RSVD: assert property (i_rd && i_addr == OFS_STS
		|=> o_rdata[31:6] == 26'h0)
		else $error("status reserved bits not zero");
	AST_INT_RSVD: assert property (i_rd && i_addr == OFS_INT
		|=> {o_rdata[31:24], o_rdata[15:8], o_rdata[6]} == 17'h0)
		else $error("event register reserved bits not zero");
	cover property (acc);
	cover property ($rose(o_irq));
	cover property ($rose(o_clamp_switch_on));
endmodule // wrxcs_chk
bind wrxcs_regs wrxcs_chk i_chk (.i_sys_clk(i_sys_clk),
	.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_modulator_switch_on(o_modulator_switch_on),
	.o_clamp_switch_on(o_clamp_switch_on),
	.o_load_dump_switch_on(o_load_dump_switch_on),
	.o_host_irq_pin(o_host_irq_pin),
	.o_host_irq_pin_oe(o_host_irq_pin_oe), .o_irq(o_irq));
`default_nettype wire

/* wrxcs_regs_tb.sv */
/* Self-checking bench for the receiver register bank.
 * Assumes the analog model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module wrxcs_regs_tb;
	import wrxcs_pkg::*;
	logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, d;
	logic [31:0] o_rdata;
	logic [5:0] cond = 6'h00, lv;
	logic [7:0] fl = 8'h00;
	logic run = 1'b1, zero = 1'b0;
	logic act, zc, pin, mod, clamp, dump, oe, irq, pv;
	int miscompares = 0, total_checks = 0, k;
	always #12.5 i_sys_clk = ~i_sys_clk;
	wrxcs_analog i_ana (.i_cond(cond), .i_coil_run(run), .i_zero(zero),
		.i_pin_oe(oe), .i_pin_val(pv), .o_lv(lv), .o_coil_active(act),
		.o_coil_zero(zc), .o_pin(pin));
	// A short timeout keeps the silent-coil scenario brief.
	wrxcs_regs #(.TMO_COUNT(20)) i_dut (.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_coil_active(act), .i_coil_zero(zc),
		.i_rectifier_overvolt_level(lv[5]), .i_output_on_level(lv[4]),
		.i_output_overcurrent_level(lv[3]),
		.i_output_overvolt_level(lv[2]),
		.i_thermal_shutdown_level(lv[1]),
		.i_thermal_warning_level(lv[0]), .o_modulator_switch_on(mod),
		.o_clamp_switch_on(clamp), .o_load_dump_switch_on(dump),
		.i_host_irq_pin(pin), .o_host_irq_pin(pv),
		.o_host_irq_pin_oe(oe), .o_irq(irq));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [31:0] a,
		input logic [31:0] e);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		chk(n, e, d);
	endtask
	task automatic uwr(input logic [31:0] v);
		wr(OFS_KEY, {24'h0, UNLOCK_VALUE});
		wr(OFS_CTRL, v);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		cyc(5);
		i_sys_rst <= 1'b0;
		rchk("key", OFS_KEY, 32'h0);
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("int", OFS_INT, 32'h0);
		rchk("unmapped", OFS_IRQ + 32'h4, 32'h0);
		rchk("pinrd", OFS_IRQ, 32'h1);
		$display("test reset done");
		wr(OFS_CTRL, 32'h9F);
		rchk("locked", OFS_CTRL, 32'h0);
		uwr(32'hFF);
		rchk("ctrl", OFS_CTRL, {24'h0, CTL_MASK});
		chk("pin", 32'h2, {oe, pin});
		rchk("pinlow", OFS_IRQ, 32'h0);
		chk("sw", 32'h5, {mod, clamp, dump});
		wr(OFS_CTRL, 32'h0);
		rchk("relock", OFS_CTRL, {24'h0, CTL_MASK});
		@(posedge i_sys_clk) zero <= 1'b1;
		cyc(6);
		chk("clampz", 32'h1, clamp);
		@(posedge i_sys_clk) zero <= 1'b0;
		cyc(4);
		uwr(32'h0);
		uwr(32'h06);
		cyc(6);
		chk("modwait", 32'h2, {mod, clamp, dump});
		@(posedge i_sys_clk) zero <= 1'b1;
		cyc(6);
		chk("modz", 32'h6, {mod, clamp, dump});
		uwr(32'h0);
		cyc(3);
		chk("off", 32'h0, {oe, mod, clamp, dump});
		$display("test switches done");
		wr(OFS_INT, 32'hFF);
		rchk("en", OFS_INT, {24'h0, EN_MASK});
		for (k = 0; k < 6; k++) begin
			@(posedge i_sys_clk) cond[k] <= 1'b1;
			cyc(6);
			fl = fl | (8'h01 << k);
			rchk("flag", OFS_INT, {8'h0, fl, 8'h0, EN_MASK});
			chk("irq", 32'h1, irq);
		end
		rchk("sts", OFS_STS, 32'h3F);
		@(posedge i_sys_clk) cond[4] <= 1'b0;
		cyc(6);
		rchk("ovr", OFS_INT, 32'h007F00BF);
		wr(OFS_INT, 32'h00FF0000);
		rchk("clr", OFS_INT, 32'h0);
		@(posedge i_sys_clk) cond[4] <= 1'b1;
		cyc(6);
		chk("mask", 32'h0, irq);
		wr(OFS_INT, 32'h10);
		rchk("keep", OFS_INT, 32'h00100010);
		chk("unmask", 32'h1, irq);
		$display("test events done");
		@(posedge i_sys_clk) run <= 1'b0;
		cyc(15);
		rchk("early", OFS_INT, 32'h00100010);
		cyc(15);
		rchk("tmo", OFS_INT, 32'h00900010);
		$display("test timeout done");
		give_verdict;
	end
endmodule // wrxcs_regs_tb
`default_nettype wire
